// ===== bocfg_pkg.sv
// What this block does
// - Hold 8-bit target code per output; zero is off.
// - Over-limit output stops gate toggling; zero limit off.
// - Peak current trip blocks phase until next cycle.
// - Enables at bits 2,1 act in operation mode.
// - Any enable starts gate supply; switch after start-up.
// - Bit 0 is configuration done, locking configuration.
// - Bit 3 counts oscillator periods while select low.
// - Clearing count enable freezes counts, keeping that transfer.
// - Count low byte at 41h, high at 42h.
// - One count step is one oscillator period.
// - Writing calibration select from one to zero starts timed calibration.
// - Calibration mode uses the default oscillator frequency.
// - Bits 5 to 1 are trim or pointer.
// - Pointer-selected calibration value readable at 4Ch.
// - Calibration select one is trimming, zero calibration.
// - Trim 00100 is default; unlisted codes refused.
package bocfg_pkg;

  // ------------------------------------------------------------
  // Register addresses
  // ------------------------------------------------------------
  localparam logic [6:0] ADDR_FUNC_CTRL = 7'h00;
  localparam logic [6:0] ADDR_TARGET_ONE = 7'h03;
  localparam logic [6:0] ADDR_TARGET_TWO = 7'h04;
  localparam logic [6:0] ADDR_LIMIT_ONE = 7'h05;
  localparam logic [6:0] ADDR_LIMIT_TWO = 7'h06;
  localparam logic [6:0] ADDR_PEAK_ONE = 7'h07;
  localparam logic [6:0] ADDR_PEAK_TWO = 7'h08;
  localparam logic [6:0] ADDR_TRIM_CAL = 7'h1c;
  localparam logic [6:0] ADDR_COUNT_LOW = 7'h41;
  localparam logic [6:0] ADDR_COUNT_HIGH = 7'h42;
  localparam logic [6:0] ADDR_CAL_RESULT = 7'h4c;

  // ------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------
  localparam int FC_CFG_DONE_BIT = 0;
  localparam int FC_OUT_ONE_EN_BIT = 1;
  localparam int FC_OUT_TWO_EN_BIT = 2;
  localparam int FC_COUNT_EN_BIT = 3;
  localparam logic [7:0] FC_WRITE_MASK = 8'h0f;
  localparam int TC_CAL_SEL_BIT = 0;
  localparam int TC_FIELD_LSB = 1;
  localparam int TC_FIELD_MSB = 5;
  localparam logic [4:0] TRIM_DEFAULT = 5'h04;
  localparam logic [7:0] FC_RESET = 8'h00;
  localparam logic [7:0] CODE_RESET = 8'h00;
  localparam logic [7:0] CODE_OFF = 8'h00;
  localparam logic [15:0] COUNT_MAX = 16'hffff;

  // ------------------------------------------------------------
  // Serial frame layout
  // ------------------------------------------------------------
  localparam int FRAME_BITS = 16;
  localparam logic [3:0] FRAME_LAST = 4'hf;
  localparam logic [3:0] RESP_FIRST = 4'h1;
  localparam logic [3:0] RESP_LAST = 4'h8;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int GATE_STARTUP_NS = 50000;
  localparam int CALIB_TIME_NS = 1000000;
  localparam int GATE_STARTUP_CYCLES = (GATE_STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CALIB_CYCLES = (CALIB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic [6:0] addr;
    logic [7:0] data;
  } bocfg_frame_t;

  typedef struct packed {
    logic [7:0] target_one;
    logic [7:0] target_two;
    logic [7:0] limit_one;
    logic [7:0] limit_two;
    logic [7:0] peak_one;
    logic [7:0] peak_two;
  } bocfg_codes_t;

endpackage

// ===== bocfg_sync.sv
`timescale 1ns/1ps
module bocfg_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Levels
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      meta_reg <= '0;
      sync_o <= '0;
    end
    else
    begin
      meta_reg <= async_i;
      sync_o <= meta_reg;
    end
  end

endmodule

// ===== bocfg_link.sv
`timescale 1ns/1ps
module bocfg_link (
  // Reset
  input wire logic rst_i,
  // Serial pins
  input wire logic serial_clk_i,
  input wire logic serial_chip_select_n_i,
  input wire logic serial_data_in_i,
  output logic serial_data_out_o,
  // Towards the system domain
  input wire logic [7:0] resp_byte_i,
  output bocfg_pkg::bocfg_frame_t frame_o,
  output logic frame_toggle_o
);

  // ------------------------------------------------------------
  // Receive
  // ------------------------------------------------------------
  // Chip select high clears the bit position, so a short frame is dropped.
  logic frame_rst;
  logic [3:0] bit_cnt_reg;
  logic [14:0] shift_reg;

  assign frame_rst = rst_i | serial_chip_select_n_i;

  always_ff @(posedge serial_clk_i or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      bit_cnt_reg <= 4'h0;
      shift_reg <= 15'h0000;
    end
    else
    begin
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
      shift_reg <= {shift_reg[13:0], serial_data_in_i};
    end
  end

  always_ff @(posedge serial_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      frame_o <= '0;
      frame_toggle_o <= 1'b0;
    end
    else if (bit_cnt_reg == bocfg_pkg::FRAME_LAST)
    begin
      frame_o <= {shift_reg, serial_data_in_i};
      frame_toggle_o <= ~frame_toggle_o;
    end
  end

  // ------------------------------------------------------------
  // Transmit
  // ------------------------------------------------------------
  // The response byte is held steady by the system domain for the whole frame.
  always_ff @(negedge serial_clk_i or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      serial_data_out_o <= 1'b0;
    end
    else if (bit_cnt_reg >= bocfg_pkg::RESP_FIRST && bit_cnt_reg <= bocfg_pkg::RESP_LAST)
    begin
      serial_data_out_o <= resp_byte_i[3'(bocfg_pkg::RESP_LAST - bit_cnt_reg)];
    end
    else
    begin
      serial_data_out_o <= 1'b0;
    end
  end

endmodule

// ===== bocfg_top.sv
`timescale 1ns/1ps
module bocfg_top #(
  parameter int unsigned GATE_STARTUP_CYCLES = bocfg_pkg::GATE_STARTUP_CYCLES,
  parameter int unsigned CALIB_CYCLES = bocfg_pkg::CALIB_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Serial pins
  input wire logic serial_clk_i,
  input wire logic serial_chip_select_n_i,
  input wire logic serial_data_in_i,
  output logic serial_data_out_o,
  output logic serial_data_out_oe_o,
  // Device state and analog status
  input wire logic operation_mode_i,
  input wire logic gate_supply_good_i,
  input wire logic [1:0] output_over_limit_i,
  input wire logic [3:0] phase_current_trip_i,
  input wire logic [3:0] phase_cycle_start_i,
  input wire logic [3:0] phase_output_sel_i,
  input wire logic [7:0] calib_result_i,
  // Analog settings
  output bocfg_pkg::bocfg_codes_t codes_o,
  output logic [1:0] peak_current_allowed_o,
  output logic [4:0] osc_trim_o,
  output logic [4:0] calib_pointer_o,
  // Power and gate control
  output logic gate_supply_enable_o,
  output logic [1:0] output_switch_o,
  output logic [3:0] phase_gate_allow_o,
  // Calibration
  output logic calib_start_o,
  output logic calib_busy_o,
  output logic calib_done_o
);

  // ------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------
  function automatic logic trim_code_valid(input logic [4:0] code);
    trim_code_valid = (code[4:3] != 2'b10) || (code[2:1] == 2'b00);
  endfunction

  function automatic logic [19:0] count_up(input logic [19:0] cnt, input int unsigned limit);
    count_up = (cnt < 20'(limit)) ? cnt + 20'h00001 : cnt;
  endfunction

  // ------------------------------------------------------------
  // Serial link and crossing
  // ------------------------------------------------------------
  bocfg_pkg::bocfg_frame_t frame;
  logic frame_toggle;
  logic [7:0] resp_byte_reg;
  logic [8:0] async_vec;
  logic [8:0] sync_vec;
  logic select_active;
  logic frame_toggle_s;
  logic gate_good_s;
  logic [1:0] over_limit_s;
  logic [3:0] trip_s;

  bocfg_link u_link (
    .rst_i(rst_i),
    .serial_clk_i(serial_clk_i),
    .serial_chip_select_n_i(serial_chip_select_n_i),
    .serial_data_in_i(serial_data_in_i),
    .serial_data_out_o(serial_data_out_o),
    .resp_byte_i(resp_byte_reg),
    .frame_o(frame),
    .frame_toggle_o(frame_toggle)
  );

  assign async_vec = {~serial_chip_select_n_i, frame_toggle, gate_supply_good_i, output_over_limit_i,
                      phase_current_trip_i};

  bocfg_sync #(
    .WIDTH(9)
  ) u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .async_i(async_vec),
    .sync_o(sync_vec)
  );

  assign select_active = sync_vec[8];
  assign frame_toggle_s = sync_vec[7];
  assign gate_good_s = sync_vec[6];
  assign over_limit_s = sync_vec[5:4];
  assign trip_s = sync_vec[3:0];

  // ------------------------------------------------------------
  // Edge detection
  // ------------------------------------------------------------
  logic select_prev_reg;
  logic toggle_prev_reg;
  logic select_fall;
  logic select_rise;
  logic frame_event;
  logic write_event;

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      select_prev_reg <= 1'b0;
      toggle_prev_reg <= 1'b0;
    end
    else
    begin
      select_prev_reg <= select_active;
      toggle_prev_reg <= frame_toggle_s;
    end
  end

  assign select_fall = select_active & ~select_prev_reg;
  assign select_rise = ~select_active & select_prev_reg;
  assign frame_event = frame_toggle_s ^ toggle_prev_reg;
  assign write_event = frame_event & frame.wr;

  // ------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------
  logic [7:0] func_ctrl_reg;
  logic cal_sel_reg;
  logic [4:0] trim_reg;
  logic [4:0] pointer_reg;
  logic cfg_locked;
  logic cal_start_req;

  assign cfg_locked = func_ctrl_reg[bocfg_pkg::FC_CFG_DONE_BIT];
  assign cal_start_req = write_event && !cfg_locked && frame.addr == bocfg_pkg::ADDR_TRIM_CAL
                         && cal_sel_reg && !frame.data[bocfg_pkg::TC_CAL_SEL_BIT] && !calib_busy_o;

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      func_ctrl_reg <= bocfg_pkg::FC_RESET;
    end
    else if (write_event && frame.addr == bocfg_pkg::ADDR_FUNC_CTRL)
    begin
      func_ctrl_reg <= frame.data & bocfg_pkg::FC_WRITE_MASK;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      codes_o <= '0;
    end
    else if (write_event && !cfg_locked)
    begin
      case (frame.addr)
        bocfg_pkg::ADDR_TARGET_ONE: codes_o.target_one <= frame.data;
        bocfg_pkg::ADDR_TARGET_TWO: codes_o.target_two <= frame.data;
        bocfg_pkg::ADDR_LIMIT_ONE: codes_o.limit_one <= frame.data;
        bocfg_pkg::ADDR_LIMIT_TWO: codes_o.limit_two <= frame.data;
        bocfg_pkg::ADDR_PEAK_ONE: codes_o.peak_one <= frame.data;
        bocfg_pkg::ADDR_PEAK_TWO: codes_o.peak_two <= frame.data;
        default: codes_o <= codes_o;
      endcase
    end
  end

  // The same field is a trim code or a result pointer depending on the select bit.
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cal_sel_reg <= 1'b1;
      trim_reg <= bocfg_pkg::TRIM_DEFAULT;
      pointer_reg <= bocfg_pkg::TRIM_DEFAULT;
    end
    else if (write_event && !cfg_locked && frame.addr == bocfg_pkg::ADDR_TRIM_CAL)
    begin
      cal_sel_reg <= frame.data[bocfg_pkg::TC_CAL_SEL_BIT];
      if (frame.data[bocfg_pkg::TC_CAL_SEL_BIT])
      begin
        if (trim_code_valid(frame.data[bocfg_pkg::TC_FIELD_MSB:bocfg_pkg::TC_FIELD_LSB]))
        begin
          trim_reg <= frame.data[bocfg_pkg::TC_FIELD_MSB:bocfg_pkg::TC_FIELD_LSB];
        end
      end
      else
      begin
        pointer_reg <= frame.data[bocfg_pkg::TC_FIELD_MSB:bocfg_pkg::TC_FIELD_LSB];
      end
    end
  end

  // ------------------------------------------------------------
  // Select low-time counter
  // ------------------------------------------------------------
  logic count_active_reg;
  logic [15:0] count_run_reg;
  logic [15:0] count_shown_reg;

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      count_active_reg <= 1'b0;
      count_run_reg <= 16'h0000;
      count_shown_reg <= 16'h0000;
    end
    else if (select_fall && func_ctrl_reg[bocfg_pkg::FC_COUNT_EN_BIT])
    begin
      count_active_reg <= 1'b1;
      count_run_reg <= 16'h0000;
    end
    else if (select_rise && count_active_reg)
    begin
      count_active_reg <= 1'b0;
      count_shown_reg <= count_run_reg;
    end
    else if (count_active_reg && count_run_reg != bocfg_pkg::COUNT_MAX)
    begin
      count_run_reg <= count_run_reg + 16'h0001;
    end
  end

  // ------------------------------------------------------------
  // Read response
  // ------------------------------------------------------------
  // The byte is taken at the start of the next frame and held through it.
  logic [6:0] read_addr_reg;
  logic [7:0] read_mux;

  always_comb
  begin
    case (read_addr_reg)
      bocfg_pkg::ADDR_FUNC_CTRL: read_mux = func_ctrl_reg;
      bocfg_pkg::ADDR_TARGET_ONE: read_mux = codes_o.target_one;
      bocfg_pkg::ADDR_TARGET_TWO: read_mux = codes_o.target_two;
      bocfg_pkg::ADDR_LIMIT_ONE: read_mux = codes_o.limit_one;
      bocfg_pkg::ADDR_LIMIT_TWO: read_mux = codes_o.limit_two;
      bocfg_pkg::ADDR_PEAK_ONE: read_mux = codes_o.peak_one;
      bocfg_pkg::ADDR_PEAK_TWO: read_mux = codes_o.peak_two;
      bocfg_pkg::ADDR_TRIM_CAL: read_mux = {2'b00, cal_sel_reg ? trim_reg : pointer_reg, cal_sel_reg};
      bocfg_pkg::ADDR_COUNT_LOW: read_mux = count_shown_reg[7:0];
      bocfg_pkg::ADDR_COUNT_HIGH: read_mux = count_shown_reg[15:8];
      bocfg_pkg::ADDR_CAL_RESULT: read_mux = calib_result_i;
      default: read_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      read_addr_reg <= bocfg_pkg::ADDR_FUNC_CTRL;
      resp_byte_reg <= 8'h00;
      serial_data_out_oe_o <= 1'b0;
    end
    else
    begin
      serial_data_out_oe_o <= select_active;
      if (frame_event)
      begin
        read_addr_reg <= frame.addr;
      end
      if (select_fall)
      begin
        resp_byte_reg <= read_mux;
      end
    end
  end

  // ------------------------------------------------------------
  // Calibration
  // ------------------------------------------------------------
  logic [19:0] calib_cnt_reg;

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      calib_cnt_reg <= 20'h00000;
      calib_start_o <= 1'b0;
      calib_busy_o <= 1'b0;
      calib_done_o <= 1'b0;
    end
    else
    begin
      calib_start_o <= cal_start_req;
      if (cal_start_req)
      begin
        calib_cnt_reg <= 20'h00000;
        calib_busy_o <= 1'b1;
        calib_done_o <= 1'b0;
      end
      else if (calib_busy_o)
      begin
        calib_cnt_reg <= count_up(calib_cnt_reg, CALIB_CYCLES);
        if (calib_cnt_reg == 20'(CALIB_CYCLES - 1))
        begin
          calib_busy_o <= 1'b0;
          calib_done_o <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      osc_trim_o <= bocfg_pkg::TRIM_DEFAULT;
      calib_pointer_o <= bocfg_pkg::TRIM_DEFAULT;
    end
    else
    begin
      osc_trim_o <= cal_sel_reg ? trim_reg : bocfg_pkg::TRIM_DEFAULT;
      calib_pointer_o <= pointer_reg;
    end
  end

  // ------------------------------------------------------------
  // Output enable, gate supply and start-up
  // ------------------------------------------------------------
  logic [1:0] output_on;
  logic [19:0] startup_cnt_reg;
  logic startup_done;

  assign output_on[0] = func_ctrl_reg[bocfg_pkg::FC_OUT_ONE_EN_BIT] & operation_mode_i;
  assign output_on[1] = func_ctrl_reg[bocfg_pkg::FC_OUT_TWO_EN_BIT] & operation_mode_i;
  assign startup_done = startup_cnt_reg >= 20'(GATE_STARTUP_CYCLES);

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      gate_supply_enable_o <= 1'b0;
      startup_cnt_reg <= 20'h00000;
    end
    else
    begin
      gate_supply_enable_o <= |output_on;
      if (!gate_supply_enable_o)
      begin
        startup_cnt_reg <= 20'h00000;
      end
      else
      begin
        startup_cnt_reg <= count_up(startup_cnt_reg, GATE_STARTUP_CYCLES);
      end
    end
  end

  // ------------------------------------------------------------
  // Gate switching
  // ------------------------------------------------------------
  logic [1:0] switch_next;
  logic [3:0] phase_block_reg;
  logic [3:0] phase_next;

  always_comb
  begin
    switch_next[0] = output_on[0] && startup_done && gate_good_s
                     && codes_o.target_one != bocfg_pkg::CODE_OFF
                     && codes_o.limit_one != bocfg_pkg::CODE_OFF && !over_limit_s[0];
    switch_next[1] = output_on[1] && startup_done && gate_good_s
                     && codes_o.target_two != bocfg_pkg::CODE_OFF
                     && codes_o.limit_two != bocfg_pkg::CODE_OFF && !over_limit_s[1];
    for (int i = 0; i < 4; i++)
    begin
      phase_next[i] = switch_next[phase_output_sel_i[i]] && !phase_block_reg[i] && !trip_s[i]
                      && peak_current_allowed_o[phase_output_sel_i[i]];
    end
  end

  // A trip in the same cycle as a cycle start keeps the phase blocked.
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      phase_block_reg <= 4'h0;
      output_switch_o <= 2'b00;
      phase_gate_allow_o <= 4'h0;
      peak_current_allowed_o <= 2'b00;
    end
    else
    begin
      phase_block_reg <= trip_s | (phase_block_reg & ~phase_cycle_start_i);
      output_switch_o <= switch_next;
      phase_gate_allow_o <= phase_next;
      peak_current_allowed_o[0] <= codes_o.peak_one != bocfg_pkg::CODE_OFF;
      peak_current_allowed_o[1] <= codes_o.peak_two != bocfg_pkg::CODE_OFF;
    end
  end

endmodule

// ===== bocfg_top_sva.sv
`timescale 1ns/1ps
module bocfg_top_sva #(
  parameter int unsigned GATE_STARTUP_CYCLES = 20,
  parameter int unsigned CALIB_CYCLES = 30
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Watched inputs
  input wire logic operation_mode_i,
  input wire logic [1:0] output_over_limit_i,
  input wire logic [3:0] phase_current_trip_i,
  // Watched outputs
  input wire bocfg_pkg::bocfg_codes_t codes_o,
  input wire logic [1:0] peak_current_allowed_o,
  input wire logic [4:0] osc_trim_o,
  input wire logic gate_supply_enable_o,
  input wire logic [1:0] output_switch_o,
  input wire logic [3:0] phase_gate_allow_o,
  input wire logic calib_start_o,
  input wire logic calib_busy_o,
  input wire logic calib_done_o
);
  localparam int GATE_LO = GATE_STARTUP_CYCLES - 1;
  localparam int CAL_LO = CALIB_CYCLES - 1;
  localparam int CAL_HI = CALIB_CYCLES + 1;
  int gate_cnt_reg;
  int busy_cnt_reg;

  // Cycles spent with the gate supply on, saturating a little past start-up.
  always_ff @(posedge clk_sys_i or posedge rst_i)
    if (rst_i) gate_cnt_reg <= 0;
    else if (!gate_supply_enable_o) gate_cnt_reg <= 0;
    else if (gate_cnt_reg <= GATE_LO + 4) gate_cnt_reg <= gate_cnt_reg + 1;

  always_ff @(posedge clk_sys_i or posedge rst_i)
    if (rst_i) busy_cnt_reg <= 0;
    else busy_cnt_reg <= calib_busy_o ? busy_cnt_reg + 1 : 0;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  reset_values_a: assert property ($fell(rst_i) |-> osc_trim_o == 5'h04 && codes_o == '0)
    else $error("reset values wrong");
  gate_supply_a: assert property (!operation_mode_i |=> !gate_supply_enable_o)
    else $error("gate supply on outside operation mode");
  startup_wait_a: assert property ($rose(|output_switch_o) |-> gate_cnt_reg >= GATE_LO)
    else $error("switching before start-up time");
  zero_code_off_a: assert property ((codes_o.target_one == 8'h00 || codes_o.limit_one == 8'h00) [*2]
    |=> !output_switch_o[0]) else $error("output one switching with zero code");
  over_limit_a: assert property (output_over_limit_i[0] [*4] |=> !output_switch_o[0])
    else $error("output one switching above limit");
  peak_zero_a: assert property ((codes_o.peak_one == 8'h00) [*2] |=> !peak_current_allowed_o[0])
    else $error("current allowed with zero peak code");
  peak_set_a: assert property ((codes_o.peak_two != 8'h00) [*3] |-> peak_current_allowed_o[1])
    else $error("current refused with nonzero peak code");
  trip_block_a: assert property (phase_current_trip_i[0] [*4] |=> !phase_gate_allow_o[0])
    else $error("phase gate on during current trip");
  cal_start_a: assert property (calib_start_o |=> !calib_start_o && calib_busy_o && !calib_done_o)
    else $error("calibration start pulse wrong");
  cal_time_a: assert property ($rose(calib_done_o) |-> busy_cnt_reg >= CAL_LO && busy_cnt_reg <= CAL_HI)
    else $error("calibration time wrong");
  cal_trim_a: assert property (calib_busy_o [*2] |-> osc_trim_o == 5'h04)
    else $error("trimmed frequency used in calibration");

  cover property (calib_done_o && !calib_busy_o);
  cover property (output_switch_o == 2'b11);
  cover property ($fell(phase_gate_allow_o[0]));
endmodule

bind bocfg_top bocfg_top_sva #(.GATE_STARTUP_CYCLES(GATE_STARTUP_CYCLES), .CALIB_CYCLES(CALIB_CYCLES)) chk_u (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .operation_mode_i(operation_mode_i),
  .output_over_limit_i(output_over_limit_i), .phase_current_trip_i(phase_current_trip_i),
  .codes_o(codes_o), .peak_current_allowed_o(peak_current_allowed_o), .osc_trim_o(osc_trim_o),
  .gate_supply_enable_o(gate_supply_enable_o), .output_switch_o(output_switch_o),
  .phase_gate_allow_o(phase_gate_allow_o), .calib_start_o(calib_start_o),
  .calib_busy_o(calib_busy_o), .calib_done_o(calib_done_o));

// ===== bocfg_spi_master.sv
`timescale 1ns/1ps
module bocfg_spi_master (
  // Serial pins
  output logic sclk_o,
  output logic cs_n_o,
  output logic mosi_o,
  input wire logic miso_i,
  // Captured reply
  output logic [7:0] rx_byte_o,
  output logic rx_tgl_o
);
  initial
  begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b1;
    rx_byte_o = 8'h00;
    rx_tgl_o = 1'b0;
  end

  // Sends one frame; hold_ns stretches the select low time after the last clock.
  task automatic xfer(input logic [15:0] tx, input int hold_ns, input bit chk);
    logic [7:0] rx;
    rx = 8'h00;
    cs_n_o = 1'b0;
    #60;
    for (int i = 15; i >= 0; i--)
    begin
      mosi_o = tx[i];
      #62.5 sclk_o = 1'b1;
      if (i < 15 && i > 6) rx = {rx[6:0], miso_i};
      #62.5 sclk_o = 1'b0;
    end
    #(hold_ns + 40);
    cs_n_o = 1'b1;
    mosi_o = ~mosi_o;
    if (chk)
    begin
      rx_byte_o = rx;
      rx_tgl_o = ~rx_tgl_o;
    end
    #120;
  endtask
endmodule

// ===== tb_top.sv
`timescale 1ns/1ps
module tb_top;
  localparam int unsigned GATE_N = 20;
  localparam int unsigned CAL_N = 30;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic op_mode = 1'b0;
  logic gate_good = 1'b0;
  logic [1:0] over_lim = 2'b00;
  logic [3:0] trip = 4'h0;
  logic [3:0] cyc_start = 4'h0;
  logic [3:0] ph_sel = 4'h0;
  logic [7:0] cal_res = 8'h00;
  logic sclk, cs_n, mosi, dout, dout_oe, miso, rx_tgl, cal_done;
  logic [1:0] sw;
  logic [7:0] rx_byte;
  logic [7:0] cv [6];
  logic [15:0] exq [$];
  logic [15:0] e_cur;
  int err_total = 0;
  int comparisons = 0;

  always #5 clk_sys_i = ~clk_sys_i;
  always @(negedge clk_sys_i) cyc_start <= 4'($urandom);
  // A released data line shows the inverse of its last level.
  assign miso = dout_oe ? dout : ~dout;

  bocfg_top #(.GATE_STARTUP_CYCLES(GATE_N), .CALIB_CYCLES(CAL_N)) dut_u (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .serial_clk_i(sclk), .serial_chip_select_n_i(cs_n),
    .serial_data_in_i(mosi), .serial_data_out_o(dout), .serial_data_out_oe_o(dout_oe),
    .operation_mode_i(op_mode), .gate_supply_good_i(gate_good), .output_over_limit_i(over_lim),
    .phase_current_trip_i(trip), .phase_cycle_start_i(cyc_start), .phase_output_sel_i(ph_sel),
    .calib_result_i(cal_res), .codes_o(), .peak_current_allowed_o(), .osc_trim_o(), .calib_pointer_o(),
    .gate_supply_enable_o(), .output_switch_o(sw), .phase_gate_allow_o(), .calib_start_o(),
    .calib_busy_o(), .calib_done_o(cal_done));

  bocfg_spi_master m_u (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso),
    .rx_byte_o(rx_byte), .rx_tgl_o(rx_tgl));

  task automatic finish_test();
    $display("errors=%0d comparisons=%0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input int tol);
    comparisons++;
    if (tol == 0 ? seen !== exp : (^seen === 1'bx || seen > exp + tol || seen + tol < exp))
    begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    m_u.xfer({1'b1, a, d}, 0, 1'b0);
  endtask

  // The reply to a read arrives in the following frame.
  task automatic rd(input logic [6:0] a, input logic [7:0] e, input logic [7:0] tol);
    exq.push_back({tol, e});
    m_u.xfer({1'b0, a, 8'h00}, 0, 1'b0);
    m_u.xfer(16'h0000, 0, 1'b1);
  endtask

  task automatic wait_hi(input int which);
    int n;
    for (n = 0; n < 500 && (which ? cal_done : &sw) !== 1'b1; n++) @(negedge clk_sys_i);
    if (n == 500)
    begin
      err_total++;
      finish_test();
    end
  endtask

  initial
  forever
  begin
    @(rx_tgl);
    e_cur = exq.pop_front();
    check(rx_byte, e_cur[7:0], int'(e_cur[15:8]));
  end

  initial
  begin
    void'($urandom(32'hd690c23c));
    ph_sel = 4'($urandom);
    cal_res = 8'($urandom);
    repeat (4) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    rst_i = 1'b0;
    repeat (4) @(negedge clk_sys_i);
    rd(7'h1c, 8'h09, 0);
    cv[0] = 8'(1 + $urandom % 200);
    cv[1] = 8'(1 + $urandom % 200);
    cv[2] = cv[0] + 8'd14;
    cv[3] = cv[1] + 8'd14;
    cv[4] = 8'(1 + $urandom % 100);
    cv[5] = 8'h64;
    for (int i = 0; i < 6; i++) wr(7'(3 + i), cv[i]);
    for (int i = 0; i < 6; i++) rd(7'(3 + i), cv[i], 0);
    wr(7'h00, 8'h01);
    wr(7'h03, ~cv[0]);
    wr(7'h1c, 8'h0b);
    rd(7'h03, cv[0], 0);
    rd(7'h1c, 8'h09, 0);
    rd(7'h00, 8'h01, 0);
    wr(7'h00, 8'h00);
    wr(7'h1c, 8'h0b);
    wr(7'h1c, 8'h25);
    rd(7'h1c, 8'h0b, 0);
    rd(7'h7f, 8'h00, 0);
    wr(7'h00, 8'h08);
    m_u.xfer(16'h8008, 5000, 1'b0);
    m_u.xfer(16'h8000, 1780, 1'b0);
    rd(7'h41, 8'h84, 2);
    rd(7'h42, 8'h01, 0);
    @(negedge clk_sys_i);
    gate_good = 1'b1;
    wr(7'h00, 8'h06);
    repeat (GATE_N + 10) @(negedge clk_sys_i);
    op_mode = 1'b1;
    wait_hi(0);
    over_lim = 2'b01;
    trip = 4'hf;
    repeat (8) @(negedge clk_sys_i);
    check(8'(sw), 8'h02, 0);
    over_lim = 2'b00;
    trip = 4'h0;
    wait_hi(0);
    wr(7'h1c, 8'h0c);
    wait_hi(1);
    rd(7'h4c, cal_res, 0);
    rd(7'h1c, 8'h0c, 0);
    @(negedge clk_sys_i);
    rst_i = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    rst_i = 1'b0;
    repeat (4) @(negedge clk_sys_i);
    rd(7'h03, 8'h00, 0);
    repeat (10) @(negedge clk_sys_i);
    if (exq.size() != 0) err_total++;
    finish_test();
  end
endmodule
